// ---- core/soft_start.sv ----
// Staged soft start of one output switch.
`timescale 1ns/10ps
module soft_start #(
  parameter int STEP_CYCLES = 25000
) (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       enable,
  output logic [1:0]      level
);
  import seq_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [1:0]       level_q;

  initial begin
    if (STEP_CYCLES < 1 || STEP_CYCLES >= (1 << CNT_W)) begin
      $error("soft_start step count out of range");
    end
  end

  // Resistance begins high (level 0) and drops one step per interval.
  always_ff @(posedge core_clk) begin
    if (!resetn || !enable) begin
      cnt_q   <= '0;
      level_q <= 2'h0;
    end else if (level_q != SOFT_FULL_LEVEL) begin
      if (cnt_q == CNT_W'(STEP_CYCLES - 1)) begin
        cnt_q   <= '0;
        level_q <= level_q + 2'h1;
      end else begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end

  assign level = level_q;
endmodule

// ---- core/supply_sequencer.sv ----
// Control logic of the dual supply output sequencer.
//
// Summary of operation
// - After settle interval with a supply out of lockout, watch enable for rising edge.
// - Control mode: enable rise pulls ready flag low after enable-to-flag delay.
// - Control mode: enable rise opens high power output after enable-to-open delay.
// - Host receive falling edges are watched only after enable-to-open delay.
// - Receive falling edge reconnects high power output after receive-to-connect delay.
// - Receive falling edge releases ready flag after receive-to-flag delay.
// - After reconnection, watch enable again so the cycle repeats.
// - No valid supply: flag held low, every switch open.
// - Both supplies in lockout: clear wait state, ignore enable and receive.
// - After mode latch, configuration pin acts as transmit output enable.
// - Soft start each newly enabled output in three steps of 250 us.
// - Primary over lockout threshold opens primary path switches.
// - After primary overvoltage, connect to valid secondary after discharge interval.
// - Primary overvoltage with invalid secondary leaves both outputs open.
// - Transmit output floats while flag low or unpowered, ignoring enable pin.
// - Flag high: transmit floats when pin low, copies cable transmit when high.
// - Low power output disconnects with no valid supply or thermal shutdown.
// - Mode latched at power-up: pin low gives control, else normal mode.
// - Normal mode: high power output connected only with supply and enable high.
// - Flag low for settle interval at power-up; control mode masks enable until flag high.
// - Cable receive output copies the host receive input while the low power output is on, else held low.
`timescale 1ns/10ps
module supply_sequencer
  import seq_pkg::*;
#(
  parameter int SETTLE_CYCLES   = seq_pkg::STARTUP_SETTLE_CYCLES,
  parameter int E2F_CYCLES      = seq_pkg::ENABLE_TO_FLAG_CYCLES,
  parameter int E2O_CYCLES      = seq_pkg::ENABLE_TO_OPEN_CYCLES,
  parameter int R2C_CYCLES      = seq_pkg::RECV_TO_CONNECT_CYCLES,
  parameter int R2F_CYCLES      = seq_pkg::RECV_TO_FLAG_CYCLES,
  parameter int HANDOVER_CYC    = seq_pkg::HANDOVER_CYCLES,
  parameter int SOFT_STEP_CYC   = seq_pkg::SOFT_STEP_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       primary_valid,
  input  wire logic       primary_high,
  input  wire logic       secondary_valid,
  input  wire logic       thermal_shutdown,
  input  wire logic       high_power_enable_in,
  input  wire logic       host_receive_in,
  input  wire logic       cable_transmit_in,
  input  wire logic       config_oe_in,
  output logic            low_power_primary_on,
  output logic            low_power_secondary_on,
  output logic            high_power_primary_on,
  output logic            high_power_secondary_on,
  output logic [1:0]      low_power_soft_level,
  output logic [1:0]      high_power_soft_level,
  output logic            output_ready_n_out,
  output logic            output_ready_n_oe,
  output logic            host_transmit_out,
  output logic            host_transmit_oe,
  output logic            cable_receive_out,
  output logic            control_mode
);
  import seq_pkg::*;

  // -----------------------------------------------------------------------
  // Parameter checks
  // -----------------------------------------------------------------------
  initial begin
    if (SETTLE_CYCLES < 1 || E2F_CYCLES < 1 || E2O_CYCLES < 1 || R2C_CYCLES < 1 ||
        R2F_CYCLES < 1 || HANDOVER_CYC < 1) begin
      $error("supply_sequencer delays must be at least one cycle");
    end
    if (SETTLE_CYCLES >= (1 << CNT_W) || HANDOVER_CYC >= (1 << CNT_W) ||
        E2F_CYCLES >= (1 << CNT_W) || E2O_CYCLES >= (1 << CNT_W) ||
        R2C_CYCLES >= (1 << CNT_W) || R2F_CYCLES >= (1 << CNT_W)) begin
      $error("supply_sequencer delay exceeds counter width");
    end
  end

  // -----------------------------------------------------------------------
  // Input synchronisers
  // -----------------------------------------------------------------------
  logic pv_s, ph_s, sv_s, tsd_s, cfg_s, en_s, en_rise, rx_s, rx_fall;

  // Comparator levels only need the synchronised level.
  sync_edge u_sync_pv  (.core_clk(core_clk), .resetn(resetn), .din(primary_valid),
                        .level(pv_s), .rise(), .fall());
  sync_edge u_sync_ph  (.core_clk(core_clk), .resetn(resetn), .din(primary_high),
                        .level(ph_s), .rise(), .fall());
  sync_edge u_sync_sv  (.core_clk(core_clk), .resetn(resetn), .din(secondary_valid),
                        .level(sv_s), .rise(), .fall());
  sync_edge u_sync_tsd (.core_clk(core_clk), .resetn(resetn), .din(thermal_shutdown),
                        .level(tsd_s), .rise(), .fall());
  sync_edge u_sync_cfg (.core_clk(core_clk), .resetn(resetn), .din(config_oe_in),
                        .level(cfg_s), .rise(), .fall());
  sync_edge u_sync_en  (.core_clk(core_clk), .resetn(resetn), .din(high_power_enable_in),
                        .level(en_s), .rise(en_rise), .fall());
  sync_edge u_sync_rx  (.core_clk(core_clk), .resetn(resetn), .din(host_receive_in),
                        .level(rx_s), .rise(), .fall(rx_fall));

  // -----------------------------------------------------------------------
  // Supply selection
  // -----------------------------------------------------------------------
  logic any_valid, use_primary, use_secondary, handover_ok;
  logic [CNT_W-1:0] ho_cnt_q;

  assign any_valid = pv_s | sv_s;

  // Once the primary rose too high, secondary may only take over after the
  // outputs had time to discharge toward the secondary level.
  always_ff @(posedge core_clk) begin
    if (!resetn || !ph_s || !sv_s) begin
      ho_cnt_q <= '0;
    end else if (ho_cnt_q != CNT_W'(HANDOVER_CYC)) begin
      ho_cnt_q <= ho_cnt_q + CNT_W'(1);
    end
  end
  assign handover_ok   = ho_cnt_q == CNT_W'(HANDOVER_CYC);
  assign use_primary   = pv_s & ~ph_s;
  // Low power output falls back to secondary when primary is merely absent.
  assign use_secondary = sv_s & ~use_primary & (ph_s ? handover_ok : 1'b1);

  // -----------------------------------------------------------------------
  // Mode latch
  // -----------------------------------------------------------------------
  logic mode_done_q, control_q;

  // The pin is sampled once when the first valid supply appears.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mode_done_q <= 1'b0;
      control_q   <= 1'b0;
    end else if (!mode_done_q && any_valid) begin
      mode_done_q <= 1'b1;
      control_q   <= ~cfg_s;
    end
  end
  assign control_mode = control_q;

  // -----------------------------------------------------------------------
  // Control sequence
  // -----------------------------------------------------------------------
  ctl_state_e       state_q;
  logic [CNT_W-1:0] cnt_q;
  logic             flag_low_q;
  logic             hp_open_q;
  logic             flag_done_q;
  logic             conn_done_q;

  always_ff @(posedge core_clk) begin
    if (!resetn || !any_valid) begin
      state_q     <= ST_OFF;
      cnt_q       <= '0;
      flag_low_q  <= 1'b1;
      hp_open_q   <= 1'b0;
      flag_done_q <= 1'b0;
      conn_done_q <= 1'b0;
    end else begin
      case (state_q)
        ST_OFF: begin
          state_q    <= ST_SETTLE;
          cnt_q      <= '0;
          flag_low_q <= 1'b1;
        end
        ST_SETTLE: begin
          if (cnt_q == CNT_W'(SETTLE_CYCLES - 1)) begin
            state_q    <= ST_WATCH;
            flag_low_q <= 1'b0;
            cnt_q      <= '0;
          end else begin
            cnt_q <= cnt_q + CNT_W'(1);
          end
        end
        ST_WATCH: begin
          if (control_q && en_rise) begin
            state_q     <= ST_OPENING;
            cnt_q       <= '0;
            flag_done_q <= 1'b0;
          end
        end
        ST_OPENING: begin
          cnt_q <= cnt_q + CNT_W'(1);
          if (cnt_q == CNT_W'(E2F_CYCLES - 1)) begin
            flag_low_q <= 1'b1;
          end
          if (cnt_q == CNT_W'(E2O_CYCLES - 1)) begin
            hp_open_q  <= 1'b1;
            flag_low_q <= 1'b1;
            state_q    <= ST_WAIT_RX;
            cnt_q      <= '0;
          end
        end
        ST_WAIT_RX: begin
          if (rx_fall) begin
            state_q     <= ST_CLOSING;
            cnt_q       <= '0;
            flag_done_q <= 1'b0;
            conn_done_q <= 1'b0;
          end
        end
        ST_CLOSING: begin
          cnt_q <= cnt_q + CNT_W'(1);
          if (cnt_q == CNT_W'(R2C_CYCLES - 1)) begin
            hp_open_q   <= 1'b0;
            conn_done_q <= 1'b1;
          end
          if (cnt_q == CNT_W'(R2F_CYCLES - 1)) begin
            flag_low_q  <= 1'b0;
            flag_done_q <= 1'b1;
          end
          if ((conn_done_q || cnt_q == CNT_W'(R2C_CYCLES - 1)) &&
              (flag_done_q || cnt_q == CNT_W'(R2F_CYCLES - 1))) begin
            state_q <= ST_WATCH;
            cnt_q   <= '0;
          end
        end
        default: begin
          state_q <= ST_OFF;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // Switch requests
  // -----------------------------------------------------------------------
  logic lp_on, hp_on, hp_src_ok, hp_primary_ok;

  assign lp_on         = (use_primary | use_secondary) & ~tsd_s;
  // High power output never runs from secondary unless primary is too high.
  assign hp_primary_ok = use_primary;
  assign hp_src_ok     = hp_primary_ok | (use_secondary & ph_s);
  // In control mode the output stays connected from the end of settling until the
  // open delay runs out; the early flag drop must not cut it before that point.
  assign hp_on         = hp_src_ok & mode_done_q &
                         (control_q ? (~hp_open_q & (state_q != ST_OFF) &
                                       (state_q != ST_SETTLE))
                                    : en_s);

  assign low_power_primary_on    = lp_on & use_primary;
  assign low_power_secondary_on  = lp_on & ~use_primary & use_secondary;
  assign high_power_primary_on   = hp_on & hp_primary_ok & any_valid;
  assign high_power_secondary_on = hp_on & ~hp_primary_ok & any_valid;

  soft_start #(.STEP_CYCLES(SOFT_STEP_CYC)) u_soft_lp (
    .core_clk (core_clk),
    .resetn   (resetn),
    .enable   (lp_on),
    .level    (low_power_soft_level)
  );
  soft_start #(.STEP_CYCLES(SOFT_STEP_CYC)) u_soft_hp (
    .core_clk (core_clk),
    .resetn   (resetn),
    .enable   (hp_on),
    .level    (high_power_soft_level)
  );

  // -----------------------------------------------------------------------
  // Ready flag and UART buffers
  // -----------------------------------------------------------------------
  logic ready_high;

  // Open drain: drive low only, release to let the pull-up raise it.
  // The flag register trails the supply loss by a cycle, so gate it directly.
  assign ready_high         = ~flag_low_q & any_valid & (control_q | hp_on);
  assign output_ready_n_out = 1'b0;
  assign output_ready_n_oe  = ~ready_high;
  assign host_transmit_oe   = ready_high & lp_on & mode_done_q & cfg_s;
  assign host_transmit_out  = cable_transmit_in;
  assign cable_receive_out  = host_receive_in & lp_on;

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  a_no_supply_off: assert property (@(posedge core_clk) disable iff (!resetn)
    !any_valid |-> !high_power_primary_on && !high_power_secondary_on && output_ready_n_oe)
    else $error("switch closed or flag released without supply");
  a_tx_float_low: assert property (@(posedge core_clk) disable iff (!resetn)
    output_ready_n_oe |-> !host_transmit_oe)
    else $error("transmit driven while flag low");
  a_rx_watch_gate: assert property (@(posedge core_clk) disable iff (!resetn)
    (state_q == ST_WATCH || state_q == ST_OPENING) && rx_fall |=> state_q != ST_CLOSING)
    else $error("receive edge acted on before the open delay ran out");
  a_lockout_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    !any_valid |=> state_q == ST_OFF)
    else $error("wait state kept in lockout");
  a_flag_delay: assert property (@(posedge core_clk) disable iff (!resetn)
    state_q == ST_OPENING && cnt_q < CNT_W'(E2F_CYCLES - 1) |-> !flag_low_q)
    else $error("flag fell before the enable-to-flag delay");
  a_flag_fall: assert property (@(posedge core_clk) disable iff (!resetn)
    state_q == ST_OPENING && cnt_q == CNT_W'(E2F_CYCLES - 1) |=> flag_low_q)
    else $error("flag not pulled low after the enable-to-flag delay");
  a_open_delay: assert property (@(posedge core_clk) disable iff (!resetn)
    control_q && state_q == ST_OPENING && hp_src_ok
    |-> high_power_primary_on || high_power_secondary_on)
    else $error("high power output opened before the enable-to-open delay");
  a_wait_open: assert property (@(posedge core_clk) disable iff (!resetn)
    state_q == ST_WAIT_RX |-> !high_power_primary_on && !high_power_secondary_on)
    else $error("high power output closed while waiting for receive edge");
  a_thermal_off: assert property (@(posedge core_clk) disable iff (!resetn)
    tsd_s |-> !low_power_primary_on && !low_power_secondary_on)
    else $error("low power output on in thermal shutdown");
  a_hv_open: assert property (@(posedge core_clk) disable iff (!resetn)
    ph_s |-> !low_power_primary_on && !high_power_primary_on)
    else $error("primary path closed while primary high");
  a_normal_enable: assert property (@(posedge core_clk) disable iff (!resetn)
    mode_done_q && !control_q && !en_s |-> !high_power_primary_on && !high_power_secondary_on)
    else $error("high power on without enable in normal mode");
  a_handover_wait: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(ph_s) |-> !low_power_secondary_on [*2])
    else $error("secondary taken without discharge wait");
endmodule

// ---- core/sync_edge.sv ----
// Two-stage synchroniser with rise and fall pulses.
`timescale 1ns/10ps
module sync_edge (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic din,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~last_q;
  assign fall  = ~sync_q & last_q;
endmodule

// ---- include/seq_pkg.sv ----
// Shared constants for the dual supply output sequencer.
package seq_pkg;
  // -----------------------------------------------------------------------
  // Clock and timing
  // -----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS          = 10;
  localparam int SOFT_STEP_US           = 250;
  localparam int SOFT_STEP_CYCLES       = (SOFT_STEP_US * 1000) / CLK_PERIOD_NS;
  localparam int SOFT_STEPS             = 4;
  // Delays not printed with figures; plain defaults, in microseconds.
  localparam int STARTUP_SETTLE_US      = 100;
  localparam int ENABLE_TO_FLAG_US      = 10;
  localparam int ENABLE_TO_OPEN_US      = 20;
  localparam int RECEIVE_TO_CONNECT_US  = 10;
  localparam int RECEIVE_TO_FLAG_US     = 20;
  localparam int HANDOVER_DISCHARGE_US  = 30;
  localparam int STARTUP_SETTLE_CYCLES  = (STARTUP_SETTLE_US * 1000) / CLK_PERIOD_NS;
  localparam int ENABLE_TO_FLAG_CYCLES  = (ENABLE_TO_FLAG_US * 1000) / CLK_PERIOD_NS;
  localparam int ENABLE_TO_OPEN_CYCLES  = (ENABLE_TO_OPEN_US * 1000) / CLK_PERIOD_NS;
  localparam int RECV_TO_CONNECT_CYCLES = (RECEIVE_TO_CONNECT_US * 1000) / CLK_PERIOD_NS;
  localparam int RECV_TO_FLAG_CYCLES    = (RECEIVE_TO_FLAG_US * 1000) / CLK_PERIOD_NS;
  localparam int HANDOVER_CYCLES        = (HANDOVER_DISCHARGE_US * 1000) / CLK_PERIOD_NS;
  localparam int CNT_W                  = 20;
  localparam logic [1:0] SOFT_FULL_LEVEL = 2'h3;

  // -----------------------------------------------------------------------
  // Control mode sequence
  // -----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_SETTLE  = 3'b001,
    ST_WATCH   = 3'b010,
    ST_OPENING = 3'b011,
    ST_WAIT_RX = 3'b100,
    ST_CLOSING = 3'b101
  } ctl_state_e;
endpackage

// ---- verif/host_model.sv ----
// Behavioural host controller that drives the enable and host receive lines.
`timescale 1ns/10ps
module host_model (
  input  wire logic core_clk,
  input  wire logic output_ready_n,
  output logic      high_power_enable_in,
  output logic      host_receive_in
);
  initial begin
    high_power_enable_in = 1'b0;
    host_receive_in      = 1'b1;
  end

  task automatic set_enable(input logic v);
    @(posedge core_clk);
    high_power_enable_in <= v;
  endtask

  // A real host waits for the ready flag before asking again; a bounded wait keeps hangs out.
  task automatic wait_ready(input int lim);
    int n;
    n = 0;
    while (output_ready_n !== 1'b1 && n < lim) begin
      @(posedge core_clk);
      n++;
    end
  endtask

  // Start-bit style low pulse; the receive line idles high between frames.
  task automatic rx_frame(input int low_cycles);
    @(posedge core_clk);
    host_receive_in <= 1'b0;
    repeat (low_cycles) @(posedge core_clk);
    host_receive_in <= 1'b1;
  endtask
endmodule

// ---- verif/supply_sequencer_tb_top.sv ----
// Self-checking testbench of the dual supply output sequencer.
`timescale 1ns/10ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module supply_sequencer_tb_top;
  localparam int SETTLE = 10;
  localparam int E2F    = 4;
  localparam int E2O    = 24;
  localparam int R2C    = 4;
  localparam int R2F    = 8;
  localparam int HO     = 6;
  localparam int STEP   = 4;

  logic       core_clk;
  logic       resetn;
  logic       primary_valid;
  logic       primary_high;
  logic       secondary_valid;
  logic       thermal_shutdown;
  logic       cable_transmit_in;
  logic       config_oe_in;
  logic       high_power_enable_in;
  logic       host_receive_in;
  logic       low_power_primary_on;
  logic       low_power_secondary_on;
  logic       high_power_primary_on;
  logic       high_power_secondary_on;
  logic [1:0] low_power_soft_level;
  logic [1:0] high_power_soft_level;
  logic       output_ready_n_out;
  logic       output_ready_n_oe;
  logic       host_transmit_out;
  logic       host_transmit_oe;
  logic       cable_receive_out;
  logic       control_mode;
  wire logic  output_ready_n;
  int         n_mismatch;
  int         tests_run;
  int         cyc = 0;
  int         t0;
  logic       cfg;
  logic       txv;

  // The flag pin is open drain with a pull-up.
  assign output_ready_n = output_ready_n_oe ? output_ready_n_out : 1'b1;

  supply_sequencer #(.SETTLE_CYCLES(SETTLE), .E2F_CYCLES(E2F), .E2O_CYCLES(E2O),
    .R2C_CYCLES(R2C), .R2F_CYCLES(R2F), .HANDOVER_CYC(HO), .SOFT_STEP_CYC(STEP))
  supply_sequencer_i (
    .core_clk(core_clk), .resetn(resetn), .primary_valid(primary_valid),
    .primary_high(primary_high), .secondary_valid(secondary_valid),
    .thermal_shutdown(thermal_shutdown), .high_power_enable_in(high_power_enable_in),
    .host_receive_in(host_receive_in), .cable_transmit_in(cable_transmit_in),
    .config_oe_in(config_oe_in), .low_power_primary_on(low_power_primary_on),
    .low_power_secondary_on(low_power_secondary_on),
    .high_power_primary_on(high_power_primary_on),
    .high_power_secondary_on(high_power_secondary_on),
    .low_power_soft_level(low_power_soft_level),
    .high_power_soft_level(high_power_soft_level),
    .output_ready_n_out(output_ready_n_out), .output_ready_n_oe(output_ready_n_oe),
    .host_transmit_out(host_transmit_out), .host_transmit_oe(host_transmit_oe),
    .cable_receive_out(cable_receive_out), .control_mode(control_mode));

  host_model host_model_i (
    .core_clk(core_clk), .output_ready_n(output_ready_n),
    .high_power_enable_in(high_power_enable_in), .host_receive_in(host_receive_in));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) cyc <= cyc + 1;

  // ---------------------------------------------------------------------
  // Expectation helpers
  // ---------------------------------------------------------------------
  // Latency windows allow for the input synchronisers and edge detection.
  function automatic bit in_win(input int d, input int lo);
    return d >= lo && d <= lo + 6;
  endfunction

  function automatic logic exp_tx_oe(input logic ready, input logic pin);
    return ready & pin;
  endfunction

  function automatic logic pick(input int which);
    case (which)
      0: pick = output_ready_n;
      1: pick = high_power_primary_on;
      2: pick = high_power_secondary_on;
      default: pick = low_power_primary_on;
    endcase
  endfunction

  task automatic wait_sig(input int which, input logic val, input int lim);
    int n;
    n = 0;
    while (pick(which) !== val && n <= lim) begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask

  task automatic results;
    $display("mismatches=%0d checks=%0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    results();
  end

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    n_mismatch = 0;
    tests_run = 0;
    void'($urandom(98021));
    resetn = 1'b0;
    primary_valid = 1'b0;
    primary_high = 1'b0;
    secondary_valid = 1'b0;
    thermal_shutdown = 1'b0;
    cable_transmit_in = 1'b0;
    config_oe_in = 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    `CHK({low_power_primary_on, high_power_primary_on}, 2'h0)
    `CHK(output_ready_n, 1'b0)
    `CHK(host_transmit_oe, 1'b0)
    @(posedge core_clk);
    resetn <= 1'b1;
    primary_valid <= 1'b1;
    #1 t0 = cyc;
    // An enable raised during settling must be masked.
    host_model_i.set_enable(1'b1);
    wait_sig(0, 1'b1, SETTLE + 20);
    `CHK(in_win(cyc - t0, SETTLE - 1), 1'b1)
    `CHK(control_mode, 1'b1)
    `CHK(low_power_primary_on, 1'b1)
    repeat (E2O + 8) @(posedge core_clk);
    #1;
    `CHK(output_ready_n, 1'b1)
    `CHK(low_power_soft_level, seq_pkg::SOFT_FULL_LEVEL)
    host_model_i.set_enable(1'b0);
    for (int k = 0; k < 3; k++) begin
      host_model_i.wait_ready(40);
      repeat (1 + $urandom_range(0, 5)) @(posedge core_clk);
      host_model_i.set_enable(1'b1);
      #1 t0 = cyc;
      wait_sig(0, 1'b0, E2F + 10);
      `CHK(in_win(cyc - t0, E2F), 1'b1)
      host_model_i.set_enable(1'b0);
      config_oe_in <= 1'b1;
      host_model_i.rx_frame(1 + $urandom_range(0, 3));
      #1;
      `CHK(host_transmit_oe, exp_tx_oe(1'b0, 1'b1))
      `CHK(cable_receive_out, host_receive_in)
      wait_sig(1, 1'b0, E2O + 10);
      `CHK(in_win(cyc - t0, E2O), 1'b1)
      // An enable pulse in the wait state must be refused.
      host_model_i.set_enable(1'($urandom_range(0, 1)));
      host_model_i.set_enable(1'b0);
      repeat (R2C + 6) @(posedge core_clk);
      #1;
      `CHK(high_power_primary_on, 1'b0)
      t0 = cyc + 1;
      host_model_i.rx_frame(1);
      #1;
      `CHK(cable_receive_out, host_receive_in)
      wait_sig(1, 1'b1, R2C + 10);
      `CHK(in_win(cyc - t0, R2C), 1'b1)
      `CHK(high_power_soft_level < 2'h3, 1'b1)
      wait_sig(0, 1'b1, R2F + 10);
      `CHK(in_win(cyc - t0, R2F), 1'b1)
      repeat (4 * STEP + 6) @(posedge core_clk);
      #1;
      `CHK(high_power_soft_level, seq_pkg::SOFT_FULL_LEVEL)
      for (int j = 0; j < 4; j++) begin
        cfg = 1'($urandom_range(0, 1));
        txv = 1'($urandom_range(0, 1));
        @(posedge core_clk);
        config_oe_in <= cfg;
        cable_transmit_in <= txv;
        secondary_valid <= 1'($urandom_range(0, 1));
        repeat (3) @(posedge core_clk);
        #1;
        `CHK(host_transmit_oe, exp_tx_oe(1'b1, cfg))
        if (cfg) `CHK(host_transmit_out, txv)
      end
      `CHK(control_mode, 1'b1)
    end
    // Loss of both supplies while waiting for the receive edge.
    host_model_i.set_enable(1'b1);
    wait_sig(1, 1'b0, E2O + 10);
    @(posedge core_clk);
    primary_valid <= 1'b0;
    secondary_valid <= 1'b0;
    config_oe_in <= 1'b0;
    host_model_i.set_enable(1'b0);
    repeat (4) @(posedge core_clk);
    host_model_i.set_enable(1'b1);
    repeat (6) @(posedge core_clk);
    #1;
    `CHK(output_ready_n, 1'b0)
    `CHK({low_power_primary_on, low_power_secondary_on}, 2'h0)
    `CHK({high_power_primary_on, high_power_secondary_on}, 2'h0)
    `CHK(host_transmit_oe, 1'b0)
    @(posedge core_clk);
    primary_valid <= 1'b1;
    #1 t0 = cyc;
    wait_sig(0, 1'b1, SETTLE + 20);
    `CHK(in_win(cyc - t0, SETTLE), 1'b1)
    `CHK(high_power_primary_on, 1'b1)
    host_model_i.set_enable(1'b0);
    // Overvoltage on the primary with a valid secondary.
    secondary_valid <= 1'b1;
    repeat (4) @(posedge core_clk);
    primary_valid <= 1'b0;
    primary_high <= 1'b1;
    #1 t0 = cyc;
    wait_sig(1, 1'b0, 8);
    `CHK({low_power_primary_on, high_power_primary_on}, 2'h0)
    wait_sig(2, 1'b1, HO + 12);
    `CHK(in_win(cyc - t0, HO), 1'b1)
    `CHK(low_power_secondary_on, 1'b1)
    @(posedge core_clk);
    primary_high <= 1'b0;
    primary_valid <= 1'b1;
    secondary_valid <= 1'b0;
    wait_sig(3, 1'b1, 20);
    @(posedge core_clk);
    primary_valid <= 1'b0;
    primary_high <= 1'b1;
    repeat (HO + 12) @(posedge core_clk);
    #1;
    `CHK({low_power_primary_on, low_power_secondary_on}, 2'h0)
    `CHK({high_power_primary_on, high_power_secondary_on}, 2'h0)
    @(posedge core_clk);
    primary_high <= 1'b0;
    primary_valid <= 1'b1;
    wait_sig(3, 1'b1, SETTLE + 20);
    @(posedge core_clk);
    thermal_shutdown <= 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    `CHK({low_power_primary_on, low_power_secondary_on}, 2'h0)
    // Normal mode after a fresh reset with the strap high.
    @(posedge core_clk);
    thermal_shutdown <= 1'b0;
    resetn <= 1'b0;
    primary_valid <= 1'b0;
    config_oe_in <= 1'b1;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    primary_valid <= 1'b1;
    repeat (SETTLE + 10) @(posedge core_clk);
    #1;
    `CHK(control_mode, 1'b0)
    `CHK(high_power_primary_on, 1'b0)
    host_model_i.set_enable(1'b1);
    wait_sig(1, 1'b1, 10);
    `CHK(high_power_primary_on, 1'b1)
    host_model_i.set_enable(1'b0);
    wait_sig(1, 1'b0, 10);
    `CHK(high_power_primary_on, 1'b0)
    results();
  end
endmodule
